/* File: design/exposure_params.svh */
// offsets, field positions, reset values and timing counts of the exposure sequencer
`ifndef EXPOSURE_PARAMS_SVH
`define EXPOSURE_PARAMS_SVH
`define REG_INTEGRATION_CONFIG 4'h0
`define REG_ROW_LEAD_HIGH 4'h1
`define REG_ROW_LEAD_LOW 4'h2
`define REG_CAPTURE_MODE_CONTROL 4'h3
`define REG_CAPTURE_WIDTH_HIGH 4'h4
`define REG_CAPTURE_WIDTH_LOW 4'h5
`define REG_ROW_DELAY_HIGH 4'h6
`define REG_ROW_DELAY_LOW 4'h7
`define REG_ROW_PIXELS_HIGH 4'h8
`define REG_ROW_PIXELS_LOW 4'h9
`define REG_WINDOW_ROWS_HIGH 4'hA
`define REG_WINDOW_ROWS_LOW 4'hB
`define REG_STATUS 4'hC
`define BIT_PARTIAL_ENABLE 0
`define BIT_SNAPSHOT_ENABLE 0
`define BIT_TRIGGER_STYLE 1
`define BIT_SHUTTER_STYLE 2
`define FLD_FRAMES_LSB 4
`define RST_PARTIAL_ENABLE 1'h1
`define RST_ROW_LEAD 15'h0010
`define RST_FRAMES 4'h1
`define RST_CAPTURE_WIDTH 16'h0001
`define RST_ROW_DELAY 13'h0000
`define RST_ROW_PIXELS 13'h0100
`define RST_WINDOW_ROWS 13'h0100
`define ROW_OP_CYCLES 16'h008C
`define PARTIAL_OVERHEAD_CYCLES 16'h0022
`define MAX_RESET_FRAMES 4'h8
`define MAX_CAPTURE_WIDTH 16'h8000
`endif

/* File: design/exposure_pkg.sv */
// types of the exposure and snapshot sequencer
package exposure_pkg;
    typedef enum logic [4:0] {
        ST_STREAM = 5'h01,
        ST_HOLD = 5'h02,
        ST_RESET = 5'h04,
        ST_CAPTURE = 5'h08,
        ST_READ = 5'h10
    } seq_state_e;

    typedef struct packed {
        logic partial_en;
        logic [14:0] lead;
        logic single_capture_state_en;
        logic trig_style;
        logic shutter_style;
        logic [3:0] frames;
        logic [15:0] width;
        logic [12:0] row_delay;
        logic [12:0] npix;
        logic [12:0] nrows;
    } cfg_s;

    typedef struct packed {
        logic row_reset;
        logic [12:0] reset_row;
        logic row_read;
        logic [12:0] read_row;
        logic sync;
    } pin_out_s;

    typedef struct packed {
        cfg_s cfg;
        seq_state_e st;
        logic [15:0] row_cnt;
        logic [12:0] row;
        logic [3:0] frame_cnt;
        logic [15:0] width_cnt;
        logic [2:0] req_sync;
        logic req_lvl;
        logic trig;
        logic [7:0] rd_data;
        pin_out_s pins;
    } seq_s;
endpackage

/* File: design/exposure_snapshot_sequencer.sv */
// rolling partial integration and snapshot sequencer with byte register port
`timescale 1ns/1ps
`include "exposure_params.svh"

module exposure_snapshot_sequencer #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic single_capture_state_req_i,
    output logic [DATA_W-1:0] rd_data_o,
    output exposure_pkg::pin_out_s pins_o
);
    // the map is byte wide and needs thirteen slots, held in four address bits
    if (ADDR_W != 4 || DATA_W != 8)
    begin : g_bad_width
        $error("exposure sequencer needs ADDR_W 4 and DATA_W 8");
    end

    exposure_pkg::seq_s q;
    exposure_pkg::seq_s d;
    logic partial_on;
    logic [15:0] row_len;
    logic tick;
    logic last_row;
    logic [3:0] frames_eff;
    logic [15:0] width_eff;
    logic [15:0] lead_sum;
    logic [15:0] lead_wrap;

    // a zero lead means no early reset at all
    assign partial_on = q.cfg.partial_en && (q.cfg.lead != 15'h0000);

    // row cycle length from the current window and delay settings
    assign row_len = `ROW_OP_CYCLES
        + (partial_on ? `PARTIAL_OVERHEAD_CYCLES : 16'h0000)
        + {3'h0, q.cfg.npix} + {3'h0, q.cfg.row_delay};
    assign tick = (q.row_cnt >= row_len - 16'h0001);
    assign last_row = (q.row >= q.cfg.nrows - 13'h0001);

    // clamp reset frames; external mode needs at least one
    always_comb
    begin
        frames_eff = q.cfg.frames;
        if (frames_eff > `MAX_RESET_FRAMES)
        begin
            frames_eff = `MAX_RESET_FRAMES;
        end
        if (q.cfg.shutter_style && frames_eff == 4'h0)
        begin
            frames_eff = 4'h1;
        end
    end

    // capture width saturates at its documented ceiling
    assign width_eff = (q.cfg.width > `MAX_CAPTURE_WIDTH) ? `MAX_CAPTURE_WIDTH
        : q.cfg.width;

    // early reset row, wrapped once at the window end; a row still past the window after that is skipped
    assign lead_sum = {3'h0, q.row} + {1'h0, q.cfg.lead};
    assign lead_wrap = (lead_sum >= {3'h0, q.cfg.nrows})
        ? lead_sum - {3'h0, q.cfg.nrows} : lead_sum;

    // next state of the whole block
    always_comb
    begin
        d = q;
        d.pins.row_reset = 1'h0;
        d.pins.row_read = 1'h0;
        d.rd_data = 8'h00;
        // register writes
        if (wr_i)
        begin
            unique case (addr_i)
                `REG_INTEGRATION_CONFIG:
                    d.cfg.partial_en = wr_data_i[`BIT_PARTIAL_ENABLE];
                `REG_ROW_LEAD_HIGH:
                    d.cfg.lead[14:8] = wr_data_i[6:0];
                `REG_ROW_LEAD_LOW:
                    d.cfg.lead[7:0] = wr_data_i;
                `REG_CAPTURE_MODE_CONTROL:
                begin
                    d.cfg.single_capture_state_en = wr_data_i[`BIT_SNAPSHOT_ENABLE];
                    d.cfg.trig_style = wr_data_i[`BIT_TRIGGER_STYLE];
                    d.cfg.shutter_style = wr_data_i[`BIT_SHUTTER_STYLE];
                    d.cfg.frames = wr_data_i[`FLD_FRAMES_LSB +: 4];
                end
                `REG_CAPTURE_WIDTH_HIGH:
                    d.cfg.width[15:8] = wr_data_i;
                `REG_CAPTURE_WIDTH_LOW:
                    d.cfg.width[7:0] = wr_data_i;
                `REG_ROW_DELAY_HIGH:
                    d.cfg.row_delay[12:8] = wr_data_i[4:0];
                `REG_ROW_DELAY_LOW:
                    d.cfg.row_delay[7:0] = wr_data_i;
                `REG_ROW_PIXELS_HIGH:
                    d.cfg.npix[12:8] = wr_data_i[4:0];
                `REG_ROW_PIXELS_LOW:
                    d.cfg.npix[7:0] = wr_data_i;
                `REG_WINDOW_ROWS_HIGH:
                    d.cfg.nrows[12:8] = wr_data_i[4:0];
                `REG_WINDOW_ROWS_LOW:
                    d.cfg.nrows[7:0] = wr_data_i;
                default:
                    d.cfg = q.cfg; // unmapped writes are dropped
            endcase
        end
        // register reads, answered in the next cycle only
        if (rd_i)
        begin
            unique case (addr_i)
                `REG_INTEGRATION_CONFIG:
                    d.rd_data = {7'h00, q.cfg.partial_en};
                `REG_ROW_LEAD_HIGH:
                    d.rd_data = {1'h0, q.cfg.lead[14:8]};
                `REG_ROW_LEAD_LOW:
                    d.rd_data = q.cfg.lead[7:0];
                `REG_CAPTURE_MODE_CONTROL:
                    d.rd_data = {q.cfg.frames, 1'h0, q.cfg.shutter_style,
                        q.cfg.trig_style, q.cfg.single_capture_state_en};
                `REG_CAPTURE_WIDTH_HIGH:
                    d.rd_data = q.cfg.width[15:8];
                `REG_CAPTURE_WIDTH_LOW:
                    d.rd_data = q.cfg.width[7:0];
                `REG_ROW_DELAY_HIGH:
                    d.rd_data = {3'h0, q.cfg.row_delay[12:8]};
                `REG_ROW_DELAY_LOW:
                    d.rd_data = q.cfg.row_delay[7:0];
                `REG_ROW_PIXELS_HIGH:
                    d.rd_data = {3'h0, q.cfg.npix[12:8]};
                `REG_ROW_PIXELS_LOW:
                    d.rd_data = q.cfg.npix[7:0];
                `REG_WINDOW_ROWS_HIGH:
                    d.rd_data = {3'h0, q.cfg.nrows[12:8]};
                `REG_WINDOW_ROWS_LOW:
                    d.rd_data = q.cfg.nrows[7:0];
                `REG_STATUS:
                    d.rd_data = {1'h0, q.trig, q.pins.sync, q.st};
                default:
                    d.rd_data = 8'h00;
            endcase
        end
        // request pin: three stages, change taken once the last two agree
        d.req_sync = {q.req_sync[1:0], single_capture_state_req_i};
        if (q.req_sync[2] == q.req_sync[1])
        begin
            d.req_lvl = q.req_sync[2];
        end
        // pulse on the rising level, or follow the level
        if (q.cfg.trig_style)
        begin
            d.trig = d.req_lvl;
        end
        else
        begin
            d.trig = d.req_lvl && !q.req_lvl;
        end
        // row timer runs freely; only leaving the hold state restarts it
        d.row_cnt = tick ? 16'h0000 : q.row_cnt + 16'h0001;
        // sequencer
        unique case (q.st)
            exposure_pkg::ST_STREAM:
            begin
                // a trigger here is simply not looked at
                if (tick)
                begin
                    d.pins.row_read = 1'h1;
                    d.pins.read_row = q.row;
                    if (partial_on && lead_wrap < {3'h0, q.cfg.nrows})
                    begin
                        d.pins.row_reset = 1'h1;
                        d.pins.reset_row = lead_wrap[12:0];
                    end
                    d.row = last_row ? 13'h0000 : q.row + 13'h0001;
                    if (last_row && q.cfg.single_capture_state_en)
                    begin
                        d.st = exposure_pkg::ST_HOLD;
                    end
                end
            end
            exposure_pkg::ST_HOLD:
            begin
                d.row = 13'h0000;
                d.frame_cnt = 4'h0;
                d.width_cnt = 16'h0000;
                if (!q.cfg.single_capture_state_en)
                begin
                    d.st = exposure_pkg::ST_STREAM;
                    d.row_cnt = 16'h0000;
                end
                else if (q.trig)
                begin
                    d.row_cnt = 16'h0000;
                    if (frames_eff != 4'h0)
                    begin
                        d.st = exposure_pkg::ST_RESET;
                    end
                    else if (width_eff != 16'h0000)
                    begin
                        d.st = exposure_pkg::ST_CAPTURE;
                    end
                    else
                    begin
                        d.st = exposure_pkg::ST_READ;
                    end
                end
            end
            exposure_pkg::ST_RESET:
            begin
                // row by row array reset, repeated per frame count
                if (tick)
                begin
                    d.pins.row_reset = 1'h1;
                    d.pins.reset_row = q.row;
                    d.row = last_row ? 13'h0000 : q.row + 13'h0001;
                    if (last_row)
                    begin
                        d.frame_cnt = q.frame_cnt + 4'h1;
                        if (q.frame_cnt + 4'h1 >= frames_eff)
                        begin
                            d.st = (width_eff != 16'h0000)
                                ? exposure_pkg::ST_CAPTURE : exposure_pkg::ST_READ;
                        end
                    end
                end
            end
            exposure_pkg::ST_CAPTURE:
            begin
                // width counted in whole row cycles
                if (tick)
                begin
                    d.width_cnt = q.width_cnt + 16'h0001;
                    if (q.width_cnt + 16'h0001 >= width_eff)
                    begin
                        d.st = exposure_pkg::ST_READ;
                    end
                end
            end
            exposure_pkg::ST_READ:
            begin
                if (tick)
                begin
                    d.pins.row_read = 1'h1;
                    d.pins.read_row = q.row;
                    d.row = last_row ? 13'h0000 : q.row + 13'h0001;
                    if (last_row)
                    begin
                        d.st = q.cfg.single_capture_state_en ? exposure_pkg::ST_HOLD
                            : exposure_pkg::ST_STREAM;
                    end
                end
            end
            default:
                d.st = exposure_pkg::ST_STREAM;
        endcase
        // sync follows the phase the row pulses of this cycle came from, so the
        // last reset row never shows sync high and, with the normal shutter, the last read row never low
        d.pins.sync = (q.st == exposure_pkg::ST_CAPTURE)
            || (q.st == exposure_pkg::ST_READ && !q.cfg.shutter_style);
    end

    // the single state register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.st <= exposure_pkg::ST_STREAM;
            q.cfg.partial_en <= `RST_PARTIAL_ENABLE;
            q.cfg.lead <= `RST_ROW_LEAD;
            q.cfg.shutter_style <= 1'h0;
            q.cfg.frames <= `RST_FRAMES;
            q.cfg.width <= `RST_CAPTURE_WIDTH;
            q.cfg.row_delay <= `RST_ROW_DELAY;
            q.cfg.npix <= `RST_ROW_PIXELS;
            q.cfg.nrows <= `RST_WINDOW_ROWS;
        end
        else
        begin
            q <= d;
        end
    end

    assign rd_data_o = q.rd_data;
    assign pins_o = q.pins;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_reset_stream;
        $past(rst_i) |-> q.st == exposure_pkg::ST_STREAM;
    endproperty
    a_reset_stream: assert property (p_reset_stream)
        else $error("not streaming after reset");

    property p_lead_row;
        q.st == exposure_pkg::ST_STREAM && tick && partial_on
            && lead_sum < {3'h0, q.cfg.nrows}
            |=> pins_o.row_reset && pins_o.reset_row == $past(lead_sum[12:0]);
    endproperty
    a_lead_row: assert property (p_lead_row)
        else $error("early reset row wrong");

    property p_no_partial_off;
        pins_o.row_reset && $past(q.st) == exposure_pkg::ST_STREAM
            |-> $past(partial_on);
    endproperty
    a_no_partial_off: assert property (p_no_partial_off)
        else $error("early reset while partial is off");

    property p_no_partial_single_capture_state;
        $past(q.st) == exposure_pkg::ST_HOLD
            || $past(q.st) == exposure_pkg::ST_CAPTURE
            || $past(q.st) == exposure_pkg::ST_READ |-> !pins_o.row_reset;
    endproperty
    a_no_partial_single_capture_state: assert property (p_no_partial_single_capture_state)
        else $error("row reset during snapshot");

    property p_enter_hold;
        q.st == exposure_pkg::ST_STREAM && tick && last_row && q.cfg.single_capture_state_en
            |=> q.st == exposure_pkg::ST_HOLD;
    endproperty
    a_enter_hold: assert property (p_enter_hold)
        else $error("hold not entered at frame end");

    property p_leave_hold;
        q.st == exposure_pkg::ST_HOLD && !q.cfg.single_capture_state_en
            |=> q.st == exposure_pkg::ST_STREAM;
    endproperty
    a_leave_hold: assert property (p_leave_hold)
        else $error("hold not left");

    property p_pulse_once;
        !q.cfg.trig_style && q.trig |=> !q.trig;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("pulse trigger longer than a cycle");

    property p_level_follow;
        q.cfg.trig_style && $past(q.cfg.trig_style) |-> q.trig == q.req_lvl;
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level trigger dropped");

    property p_sync_low_reset;
        $past(q.st) == exposure_pkg::ST_RESET |-> !pins_o.sync;
    endproperty
    a_sync_low_reset: assert property (p_sync_low_reset)
        else $error("sync high in reset phase");

    property p_sync_capture;
        $past(q.st) == exposure_pkg::ST_CAPTURE |-> pins_o.sync;
    endproperty
    a_sync_capture: assert property (p_sync_capture)
        else $error("sync low in capture");

    property p_sync_read;
        $past(q.st) == exposure_pkg::ST_READ
            && !$past(q.cfg.shutter_style) |-> pins_o.sync;
    endproperty
    a_sync_read: assert property (p_sync_read)
        else $error("sync low in normal readout");

    property p_end_read;
        q.st == exposure_pkg::ST_READ && tick && last_row
            |=> q.st == ($past(q.cfg.single_capture_state_en) ? exposure_pkg::ST_HOLD
                : exposure_pkg::ST_STREAM);
    endproperty
    a_end_read: assert property (p_end_read)
        else $error("wrong state after readout");

    property p_row_len;
        tick |=> q.row_cnt == 16'h0000
            ##1 (q.row_cnt == 16'h0001 || $past(q.st) == exposure_pkg::ST_HOLD);
    endproperty
    a_row_len: assert property (p_row_len)
        else $error("row timer did not restart");
endmodule

/* File: test/capture_host_model.sv */
// host-side model: drives the capture request pin and watches the sync output
`timescale 1ns/1ps
module capture_host_model (
    input wire logic clk_i,
    input wire logic sync_i,
    output logic single_capture_state_req_o
);
    int sync_rises = 0;
    logic sync_prev = 1'b0;
    initial single_capture_state_req_o = 1'b0;
    // count strobe firings; a double firing would mean a repeated capture
    always @(posedge clk_i)
    begin
        if (sync_i && !sync_prev)
            sync_rises++;
        sync_prev <= sync_i;
    end
    // request held n clocks; longer than a frame when a capture is wanted
    task automatic hold_request(input int n);
        @(posedge clk_i);
        single_capture_state_req_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        single_capture_state_req_o <= 1'b0;
    endtask
    // plain level drive for the level trigger style
    task automatic set_level(input logic v);
        @(posedge clk_i);
        single_capture_state_req_o <= v;
    endtask
endmodule

/* File: test/tb.sv */
// self-checking bench of the exposure and snapshot sequencer
`timescale 1ns/1ps
module tb;
    localparam int RC = 195;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic single_capture_state_req_i;
    logic [7:0] rd_data_o;
    exposure_pkg::pin_out_s pins_o;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    int n_rst = 0;
    int n_rd = 0;
    int n_rd_sync = 0;
    int n_rst_sync = 0;
    int n_sync = 0;
    logic [7:0] d;

    exposure_snapshot_sequencer exposure_snapshot_sequencer_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .single_capture_state_req_i(single_capture_state_req_i),
        .rd_data_o(rd_data_o),
        .pins_o(pins_o)
    );

    capture_host_model capture_host_model_i (
        .clk_i(clk_i),
        .sync_i(pins_o.sync),
        .single_capture_state_req_o(single_capture_state_req_i)
    );

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // pin event counters, sampled mid-cycle where pins are settled; cuts a hang short
    always @(negedge clk_i)
    begin
        cycles++;
        if (pins_o.row_read)
        begin
            n_rd++;
            if (pins_o.sync)
                n_rd_sync++;
        end
        if (pins_o.row_reset)
        begin
            n_rst++;
            if (pins_o.sync)
                n_rst_sync++;
        end
        if (pins_o.sync)
            n_sync++;
        if (cycles == 30000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rd_data_o;
    endtask

    task automatic wait_state(input logic [4:0] s);
        int n = 0;
        do
        begin
            rd(4'hC, d);
            n++;
        end
        while (d[4:0] !== s && n < 4000);
        chk(d[4:0], s);
    endtask

    task automatic next_read();
        do
        begin
            @(posedge clk_i);
            #1;
        end
        while (pins_o.row_read !== 1'b1);
    endtask

    // second gap measured, so a mid-row register write cannot skew it
    task automatic meas(input int exp);
        int n = 0;
        next_read();
        next_read();
        do
        begin
            @(posedge clk_i);
            #1 n++;
        end
        while (pins_o.row_read !== 1'b1);
        chk(n, exp);
    endtask

    task automatic clr();
        n_rst = 0;
        n_rd = 0;
        n_rd_sync = 0;
        n_rst_sync = 0;
        n_sync = 0;
    endtask

    task automatic t_regs();
        logic [7:0] ex [13] = '{8'h01, 8'h00, 8'h10, 8'h10, 8'h00, 8'h01, 8'h00,
            8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
        wr(4'hC, 8'hFF);
        for (int i = 0; i < 13; i++)
        begin
            rd(i[3:0], d);
            chk(d, ex[i]);
        end
        rd(4'hD, d);
        chk(d, 8'h00);
        rd(4'h0, d);
        @(posedge clk_i);
        #1 chk(rd_data_o, 8'h00); // read data stand one cycle only
        $display("test regs done");
    endtask

    // four rows of 16 pixels, delay 5: short frames keep the run brief
    task automatic t_row();
        wr(4'hA, 8'h00);
        wr(4'hB, 8'h04);
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h10);
        wr(4'h7, 8'h05);
        wr(4'h2, 8'h02);
        meas(RC);
        repeat (4)
        begin
            next_read();
            chk(pins_o.row_reset, 1'b1);
            chk((pins_o.reset_row + 13'h0004 - pins_o.read_row) % 4, 2);
        end
        wr(4'h0, 8'h00);
        meas(RC - 34);
        wr(4'h0, 8'h01);
        wr(4'h2, 8'h00);
        meas(RC - 34);
        wr(4'h2, 8'h02);
        meas(RC);
        $display("test row timing done");
    endtask

    task automatic t_normal();
        capture_host_model_i.hold_request(40);
        rd(4'hC, d);
        chk(d[5:0], 6'h01);
        wr(4'h5, 8'h02);
        wr(4'h3, 8'h21);
        wait_state(exposure_pkg::ST_HOLD);
        chk(pins_o.read_row, 3);
        clr();
        repeat (2 * RC) @(posedge clk_i);
        chk(n_rd + n_rst, 0);
        capture_host_model_i.hold_request(1000);
        wait_state(exposure_pkg::ST_HOLD);
        chk(n_rst, 8);
        chk(n_rst_sync, 0);
        chk(n_rd_sync, 4);
        chk((n_sync + RC / 2) / RC, 6);
        repeat (3 * RC) @(posedge clk_i);
        chk(n_rd, 4);
        chk(capture_host_model_i.sync_rises, 1);
        $display("test normal snapshot done");
    endtask

    // external shutter with zero frames asked: one reset frame still runs
    task automatic t_ext();
        wr(4'h5, 8'h03);
        wr(4'h3, 8'h05);
        clr();
        capture_host_model_i.hold_request(1000);
        wait_state(exposure_pkg::ST_HOLD);
        chk(n_rst, 4);
        chk((n_sync + RC / 2) / RC, 3);
        chk(n_rd, 4);
        chk(n_rd_sync, 0);
        $display("test external snapshot done");
    endtask

    task automatic t_level();
        int holds = 0;
        wr(4'h3, 8'h07);
        capture_host_model_i.set_level(1'b1);
        repeat (20) @(posedge clk_i);
        rd(4'hC, d);
        chk(d[6], 1'b1);
        repeat (2 * RC) @(posedge clk_i);
        rd(4'hC, d);
        chk(d[6], 1'b1);
        wr(4'h3, 8'h06);
        capture_host_model_i.set_level(1'b0);
        do
        begin
            rd(4'hC, d);
            if (d[4:0] === exposure_pkg::ST_HOLD)
                holds++;
        end
        while (d[4:0] !== exposure_pkg::ST_STREAM && cycles < 29000);
        chk(d[4:0], exposure_pkg::ST_STREAM);
        chk(holds, 0);
        chk(d[6], 1'b0);
        $display("test level trigger done");
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_row();
        t_normal();
        t_ext();
        t_level();
        summarize();
    end
endmodule
